// ===== pkg/fms_params.svh
// Timing counts, field widths and sizes of the fail mode supervisor.
// Assumes a core clock of 10 MHz; every count but FMS_CYC_SYNC derives from its printed time.
`ifndef FMS_PARAMS_SVH
`define FMS_PARAMS_SVH

// ************************************************************
// Core clock
// ************************************************************
`define FMS_CLK_PERIOD_NS 100

// ************************************************************
// Printed times
// ************************************************************
`define FMS_T_IN_DGL_NS   200000
`define FMS_T_CLK_DGL_NS  2000
`define FMS_T_RST_DGL_NS  10000
`define FMS_T_WD_SEL0_MS  32
`define FMS_T_WD_SEL1_MS  128
`define FMS_F_CLK_LOW_HZ  100

// ************************************************************
// Derived cycle counts
// ************************************************************
`define FMS_CYC_IN_DGL  ((`FMS_T_IN_DGL_NS + `FMS_CLK_PERIOD_NS - 1) / `FMS_CLK_PERIOD_NS)
`define FMS_CYC_CLK_DGL ((`FMS_T_CLK_DGL_NS + `FMS_CLK_PERIOD_NS - 1) / `FMS_CLK_PERIOD_NS)
`define FMS_CYC_RST_DGL ((`FMS_T_RST_DGL_NS + `FMS_CLK_PERIOD_NS - 1) / `FMS_CLK_PERIOD_NS)
`define FMS_CYC_WD_SEL0 (`FMS_T_WD_SEL0_MS * 1000000 / `FMS_CLK_PERIOD_NS)
`define FMS_CYC_WD_SEL1 (`FMS_T_WD_SEL1_MS * 1000000 / `FMS_CLK_PERIOD_NS)
`define FMS_CYC_CLK_LOW (1000000000 / (`FMS_F_CLK_LOW_HZ * `FMS_CLK_PERIOD_NS))
`define FMS_CYC_SYNC    1

// ************************************************************
// Sizes and reset values
// ************************************************************
`define FMS_N_CH        4
`define FMS_WORD_LSB_W  4
`define FMS_FRAME_CNT_W 8
`define FMS_RST_TOGGLE  1'b0

`endif

// ===== pkg/fms_pkg.sv
// Types shared by the fail mode supervisor files.
// Assumes nothing beyond the compile order.
package fms_pkg;

	// ************************************************************
	// Operating mode
	// ************************************************************
	typedef enum logic [1:0] {
		FMS_ST_NORMAL = 2'b01,
		FMS_ST_FAIL   = 2'b10
	} fms_mode_t;

endpackage

// ===== rtl/fms_deglitch.sv
// Two-flop synchroniser followed by a counting deglitch filter.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/1ps

module fms_deglitch
	import fms_pkg::*;
#(
	parameter int unsigned CYC       = 1,
	parameter bit          FALL_ONLY = 1'b0
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic pin_i,
	output logic      sync_o,
	output logic      filt_o
);

	logic        meta_r;
	logic        sync_r;
	logic        filt_r;
	logic [31:0] cnt_r;

	// ************************************************************
	// Synchroniser
	// ************************************************************
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	// ************************************************************
	// Filter
	// ************************************************************
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r  <= 32'h0;
			filt_r <= 1'b0;
		end else if (sync_r == filt_r) begin
			cnt_r <= 32'h0;
		end else if (FALL_ONLY && sync_r) begin
			filt_r <= 1'b1;
			cnt_r  <= 32'h0;
		end else if (cnt_r >= CYC - 1) begin
			filt_r <= sync_r;
			cnt_r  <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	assign sync_o = sync_r;
	assign filt_o = filt_r;

endmodule

// ===== rtl/fms_supervisor.sv
// Fail mode supervisor: mode decision, link watchdog, input filters,
// clock-fail detection and external switch control.
// Assumes frame strobes, PWM drive and settings come from core_clk_i logic;
// pins and the PWM clock input are asynchronous.
//
// Contract
// - In normal mode each channel follows the internal PWM drive.
// - A high forced-fail input puts the device into fail mode.
// - In fail mode each channel follows its filtered direct input.
// - The forced-fail input level is visible as a status bit.
// - Any link fault switches the device into fail mode.
// - A frame whose toggle bit did not invert is a link fault.
// - No good frame within 32 ms or 128 ms is a link fault.
// - A frame whose bit count is no multiple of 16 is a link fault.
// - A link fault sets the link failure flag for reporting.
// - The link failure flag keeps its state while in fail mode.
// - The link failure flag clears on the fail to normal transition.
// - Forced-fail and direct inputs are deglitched both edges, 200 us.
// - Filtered fail request rises only after 200 us high input.
// - Filtered direct input rises only after 200 us high input.
// - Wake reset input filtered on falling edge only, 10 us.
// - PWM clock deglitched 2 us; too fast toggling reads as failure.
// - Low clock frequency monitoring starts at wake reset rising edge.
// - While clock is too slow in normal mode channels follow their on commands.
// - Once the clock is valid channels return to PWM drive.
// - Clock-fail diagnosis clears after fault gone and quick status read.
// - External switch follows channel 6 setting in normal mode only.
// - External switch is held low in sleep and fail mode.
// - Lost link supply makes frames vanish, ending in watchdog timeout.
`timescale 1ns/1ps
`include "fms_params.svh"

module fms_supervisor
	import fms_pkg::*;
#(
	parameter int unsigned N_CH        = `FMS_N_CH,
	parameter int unsigned FRAME_CNT_W = `FMS_FRAME_CNT_W,
	parameter int unsigned IN_DGL_CYC  = `FMS_CYC_IN_DGL,
	parameter int unsigned WD_SEL0_CYC = `FMS_CYC_WD_SEL0,
	parameter int unsigned WD_SEL1_CYC = `FMS_CYC_WD_SEL1,
	parameter int unsigned CLK_LOW_CYC = `FMS_CYC_CLK_LOW
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   fail_force_i,
	input  wire logic [N_CH-1:0]        direct_channel_i,
	input  wire logic                   wake_reset_i,
	input  wire logic                   pwm_clk_i,
	input  wire logic                   spi_supply_ok_i,
	input  wire logic                   frame_done_i,
	input  wire logic [FRAME_CNT_W-1:0] frame_bits_i,
	input  wire logic                   watchdog_toggle_bit_i,
	input  wire logic                   watchdog_period_select_i,
	input  wire logic [N_CH-1:0]        pwm_drive_i,
	input  wire logic [N_CH-1:0]        channel_on_command_i,
	input  wire logic                   ch6_setting_i,
	input  wire logic                   quick_status_read_i,
	output logic [N_CH-1:0]             channel_out_o,
	output logic                        ext_switch_control_o,
	output logic                        fail_mode_o,
	output logic                        link_failure_flag_o,
	output logic                        fail_input_status_o,
	output logic                        fail_request_filtered_o,
	output logic [N_CH-1:0]             direct_input_filtered_o,
	output logic                        clk_low_o,
	output logic                        clk_fail_diag_o
);

	fms_mode_t         mode_r;
	fms_mode_t         mode_nxt;
	logic              fail_req_filt;
	logic              fail_sync;
	logic [N_CH-1:0]   dir_filt;
	logic              wake_filt;
	logic              clk_filt;
	logic              clk_filt_d_r;
	logic              clk_rise;
	logic              supply_ok;
	logic              frame_acc;
	logic              len_err;
	logic              tog_err;
	logic              frame_good;
	logic              wd_to;
	logic              comm_event;
	logic              comm_fault_r;
	logic              last_tog_r;
	logic [31:0]       wd_cnt_r;
	logic [31:0]       wd_limit;
	logic [31:0]       clk_cnt_r;
	logic              clk_low_r;
	logic              clk_diag_r;
	logic              flag_r;
	logic [N_CH-1:0]   chan_r;
	logic              ext_r;

	// ************************************************************
	// Input filters
	// ************************************************************
	fms_deglitch #(
		.CYC       (IN_DGL_CYC),
		.FALL_ONLY (1'b0)
	) u_fail_dgl (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.pin_i      (fail_force_i),
		.sync_o     (fail_sync),
		.filt_o     (fail_req_filt)
	);

	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_dir
			fms_deglitch #(
				.CYC       (IN_DGL_CYC),
				.FALL_ONLY (1'b0)
			) u_dir_dgl (
				.core_clk_i (core_clk_i),
				.reset_i    (reset_i),
				.pin_i      (direct_channel_i[g]),
				.sync_o     (),
				.filt_o     (dir_filt[g])
			);
		end
	endgenerate

	fms_deglitch #(
		.CYC       (`FMS_CYC_RST_DGL),
		.FALL_ONLY (1'b1)
	) u_wake_dgl (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.pin_i      (wake_reset_i),
		.sync_o     (),
		.filt_o     (wake_filt)
	);

	fms_deglitch #(
		.CYC       (`FMS_CYC_CLK_DGL),
		.FALL_ONLY (1'b0)
	) u_clk_dgl (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.pin_i      (pwm_clk_i),
		.sync_o     (),
		.filt_o     (clk_filt)
	);

	fms_deglitch #(
		.CYC       (`FMS_CYC_SYNC),
		.FALL_ONLY (1'b0)
	) u_supply_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.pin_i      (spi_supply_ok_i),
		.sync_o     (),
		.filt_o     (supply_ok)
	);

	// ************************************************************
	// Link watchdog
	// ************************************************************
	assign frame_acc  = frame_done_i && supply_ok;
	assign len_err    = frame_acc && (frame_bits_i[`FMS_WORD_LSB_W-1:0] != '0);
	assign tog_err    = frame_acc && !len_err && (watchdog_toggle_bit_i == last_tog_r);
	assign frame_good = frame_acc && !len_err && !tog_err;
	assign wd_limit   = watchdog_period_select_i ? WD_SEL1_CYC : WD_SEL0_CYC;
	assign wd_to      = !frame_good && (wd_cnt_r >= wd_limit - 1);
	assign comm_event = len_err || tog_err || wd_to;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			last_tog_r <= `FMS_RST_TOGGLE;
		end else if (frame_acc && !len_err) begin
			last_tog_r <= watchdog_toggle_bit_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wd_cnt_r <= 32'h0;
		end else if (frame_good) begin
			wd_cnt_r <= 32'h0;
		end else if (wd_cnt_r < wd_limit - 1) begin
			wd_cnt_r <= wd_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			comm_fault_r <= 1'b0;
		end else if (comm_event) begin
			comm_fault_r <= 1'b1;
		end else if (frame_good) begin
			comm_fault_r <= 1'b0;
		end
	end

	// ************************************************************
	// Mode decision
	// ************************************************************
	always_comb begin
		case (mode_r)
			FMS_ST_NORMAL: begin
				if (fail_req_filt || comm_fault_r) begin
					mode_nxt = FMS_ST_FAIL;
				end else begin
					mode_nxt = FMS_ST_NORMAL;
				end
			end
			FMS_ST_FAIL: begin
				if (fail_req_filt || comm_fault_r) begin
					mode_nxt = FMS_ST_FAIL;
				end else begin
					mode_nxt = FMS_ST_NORMAL;
				end
			end
			default: begin
				mode_nxt = FMS_ST_FAIL;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_r <= FMS_ST_NORMAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_r <= 1'b0;
		end else if (comm_event) begin
			flag_r <= 1'b1;
		end else if (mode_r == FMS_ST_FAIL && mode_nxt == FMS_ST_NORMAL) begin
			flag_r <= 1'b0;
		end
	end

	// ************************************************************
	// Clock monitor
	// ************************************************************
	assign clk_rise = clk_filt && !clk_filt_d_r;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_filt_d_r <= 1'b0;
		end else begin
			clk_filt_d_r <= clk_filt;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_cnt_r <= 32'h0;
			clk_low_r <= 1'b0;
		end else if (!wake_filt || clk_rise) begin
			clk_cnt_r <= 32'h0;
			clk_low_r <= 1'b0;
		end else if (clk_cnt_r >= CLK_LOW_CYC - 1) begin
			clk_low_r <= 1'b1;
		end else begin
			clk_cnt_r <= clk_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_diag_r <= 1'b0;
		end else if (clk_low_r) begin
			clk_diag_r <= 1'b1;
		end else if (quick_status_read_i) begin
			clk_diag_r <= 1'b0;
		end
	end

	// ************************************************************
	// Output drive
	// ************************************************************
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			chan_r <= '0;
		end else if (mode_r == FMS_ST_FAIL) begin
			chan_r <= dir_filt;
		end else if (clk_low_r) begin
			chan_r <= channel_on_command_i;
		end else begin
			chan_r <= pwm_drive_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ext_r <= 1'b0;
		end else begin
			ext_r <= (mode_r == FMS_ST_NORMAL) && wake_filt && ch6_setting_i;
		end
	end

	assign channel_out_o           = chan_r;
	assign ext_switch_control_o    = ext_r;
	assign fail_mode_o             = (mode_r == FMS_ST_FAIL);
	assign link_failure_flag_o     = flag_r;
	assign fail_input_status_o     = fail_sync;
	assign fail_request_filtered_o = fail_req_filt;
	assign direct_input_filtered_o = dir_filt;
	assign clk_low_o               = clk_low_r;
	assign clk_fail_diag_o         = clk_diag_r;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_fail_entry_req: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		fail_req_filt |=> fail_mode_o ##1 fail_mode_o || !$past(fail_req_filt)
	) else $error("Fail request did not hold fail mode.");

	chk_fault_to_fail: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		comm_event |=> comm_fault_r ##1 fail_mode_o
	) else $error("Link fault did not reach fail mode.");

	chk_fail_direct: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		fail_mode_o |=> channel_out_o == $past(dir_filt)
	) else $error("Fail mode channel does not follow direct input.");

	chk_normal_pwm: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!fail_mode_o && !clk_low_r |=> channel_out_o == $past(pwm_drive_i)
	) else $error("Normal mode channel does not follow PWM drive.");

	chk_clk_low_cmd: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!fail_mode_o && clk_low_r |=> channel_out_o == $past(channel_on_command_i)
	) else $error("Slow clock channel does not follow on command.");

	chk_toggle_err: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		frame_acc && !len_err && watchdog_toggle_bit_i == last_tog_r
		|=> comm_fault_r && link_failure_flag_o
	) else $error("Missing toggle was not flagged.");

	chk_length_err: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		frame_acc && frame_bits_i[`FMS_WORD_LSB_W-1:0] != '0 |=> comm_fault_r
	) else $error("Bad frame length was not flagged.");

	chk_wd_timeout: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!frame_good && wd_cnt_r == wd_limit - 1 |=> comm_fault_r
	) else $error("Watchdog expiry was not flagged.");

	chk_flag_held: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		fail_mode_o && mode_nxt == FMS_ST_FAIL && !comm_event |=> $stable(link_failure_flag_o)
	) else $error("Link failure flag changed in fail mode.");

	chk_flag_clear: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		fail_mode_o && mode_nxt == FMS_ST_NORMAL && !comm_event
		|=> !link_failure_flag_o && !fail_mode_o
	) else $error("Link failure flag not cleared on return to normal.");

	chk_ext_off: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		fail_mode_o || !wake_filt |=> !ext_switch_control_o
	) else $error("External switch on in fail or sleep.");

	chk_diag_hold: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		clk_diag_r && (clk_low_r || !quick_status_read_i) |=> clk_diag_r
	) else $error("Clock fail diagnosis cleared too early.");

	chk_clk_start: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!wake_filt |=> clk_cnt_r == 32'h0 && !clk_low_r
	) else $error("Clock monitor ran while asleep.");

endmodule

// ===== verification/fms_host_model.sv
// Host model: sends link frame strobes and makes the PWM clock pin.
// Assumes kind_i and the clock settings change only off the rising clock edge.
`timescale 1ns/1ps

module fms_host_model (
	input  wire logic        core_clk_i,
	input  wire logic [1:0]  kind_i,
	input  wire logic        clk_run_i,
	input  wire logic [15:0] clk_half_ns_i,
	output logic             frame_done_o,
	output logic [7:0]       frame_bits_o,
	output logic             toggle_o,
	output logic             pwm_clk_o
);
	logic tog_r;

	// ************************************************************
	// Frames every 21 cycles: 0 good, 1 stale toggle, 2 bad length, 3 none
	// ************************************************************
	initial begin
		frame_done_o = 1'b0;
		frame_bits_o = 8'h00;
		toggle_o = 1'b0;
		tog_r = 1'b0;
		forever begin
			repeat (20) @(negedge core_clk_i);
			if (kind_i != 2'h3) begin
				frame_done_o = 1'b1;
				frame_bits_o = (kind_i == 2'h2) ? 8'h11 : 8'h10;
				toggle_o = (kind_i == 2'h1) ? tog_r : ~tog_r;
				if (kind_i == 2'h0) begin
					tog_r = toggle_o;
				end
				@(negedge core_clk_i);
				frame_done_o = 1'b0;
				frame_bits_o = ~frame_bits_o;
				toggle_o = ~toggle_o;
			end
		end
	end

	// ************************************************************
	// PWM clock: stands low while stopped
	// ************************************************************
	initial begin
		pwm_clk_o = 1'b0;
		forever begin
			if (clk_run_i) begin
				#(clk_half_ns_i) pwm_clk_o = ~pwm_clk_o;
			end else begin
				pwm_clk_o = 1'b0;
				@(negedge core_clk_i);
			end
		end
	end
endmodule

// ===== verification/testbench.sv
// Self-checking bench of the fail mode supervisor with a host model.
// Assumes shortened counts: input deglitch 10, watchdog 50 and 100, clock low 200.
`timescale 1ns/1ps

module testbench
	import fms_pkg::*;
;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        fail_force = 1'b0;
	logic [3:0]  direct = 4'h0;
	logic        wake = 1'b1;
	logic        supply = 1'b1;
	logic        watchdog_period_select = 1'b0;
	logic [3:0]  pwm_drive = 4'h5;
	logic [1:0]  kind = 2'h0;
	logic        clk_run = 1'b1;
	logic [15:0] clk_half = 16'h09C4;
	logic        qs_read = 1'b0;
	logic        ch6 = 1'b1;
	logic [3:0]  on_cmd = 4'h9;
	logic        frame_done, toggle, pwm_clk;
	logic [7:0]  frame_bits;
	logic [3:0]  ch_out, direct_f;
	logic        ext_sw, fail_mode, link_flag, fail_stat, fail_req, clk_low, clk_diag;
	logic [6:0]  mon;
	int          bad_count = 0;
	int          comparisons = 0;
	int          waited, since, i;
	int          kinds[5] = '{1, 2, 3, 3, 0};
	int          lims[5] = '{0, 0, 50, 100, 0};

	assign mon = {fail_stat, ext_sw, clk_diag, clk_low, fail_req, link_flag, fail_mode};

	fms_supervisor #(.IN_DGL_CYC(10), .WD_SEL0_CYC(50), .WD_SEL1_CYC(100),
		.CLK_LOW_CYC(200)) fms_supervisor_i (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .fail_force_i(fail_force),
		.direct_channel_i(direct), .wake_reset_i(wake), .pwm_clk_i(pwm_clk),
		.spi_supply_ok_i(supply), .frame_done_i(frame_done), .frame_bits_i(frame_bits),
		.watchdog_toggle_bit_i(toggle), .watchdog_period_select_i(watchdog_period_select),
		.pwm_drive_i(pwm_drive), .channel_on_command_i(on_cmd), .ch6_setting_i(ch6),
		.quick_status_read_i(qs_read), .channel_out_o(ch_out), .ext_switch_control_o(ext_sw),
		.fail_mode_o(fail_mode), .link_failure_flag_o(link_flag),
		.fail_input_status_o(fail_stat), .fail_request_filtered_o(fail_req),
		.direct_input_filtered_o(direct_f), .clk_low_o(clk_low), .clk_fail_diag_o(clk_diag));

	fms_host_model fms_host_model_i (
		.core_clk_i(core_clk_i), .kind_i(kind), .clk_run_i(clk_run),
		.clk_half_ns_i(clk_half), .frame_done_o(frame_done), .frame_bits_o(frame_bits),
		.toggle_o(toggle), .pwm_clk_o(pwm_clk));

	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) since <= frame_done ? 0 : since + 1;

	// ************************************************************
	// Compare, wait, quick status read and verdict tasks
	// ************************************************************
	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task check_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task check_flag(input logic got, input logic exp);
		check_word({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic wait_until(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (mon[b] !== v && n < lim) begin
			@(negedge core_clk_i);
			n++;
		end
		waited = n;
		check_flag(mon[b], v);
		if (mon[b] !== v) begin
			give_verdict();
		end
	endtask

	task qs_pulse();
		qs_read = 1'b1;
		@(negedge core_clk_i);
		qs_read = 1'b0;
		repeat (2) @(negedge core_clk_i);
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (5) @(negedge core_clk_i);
		check_word({9'h000, mon}, 16'h0000);
		reset_i = 1'b0;
		repeat (30) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h0005);
		check_flag(ext_sw, 1'b1);
		ch6 = 1'b0;
		repeat (2) @(negedge core_clk_i);
		check_flag(ext_sw, 1'b0);
		ch6 = 1'b1;
		pwm_drive = 4'hA;
		repeat (2) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h000A);
		$display("test normal done");
		for (i = 0; i < 5; i++) begin
			kind = kinds[i][1:0];
			watchdog_period_select = (i == 3);
			supply = (i != 4);
			wait_until(1, 1'b1, 200);
			if (lims[i] > 0) begin
				check_flag(since >= lims[i] - 1 && since <= lims[i] + 3, 1'b1);
			end
			wait_until(0, 1'b1, 4);
			repeat (2) @(negedge core_clk_i);
			check_flag(ext_sw, 1'b0);
			check_word({12'h000, ch_out}, 16'h0000);
			repeat (60) @(negedge core_clk_i);
			check_flag(link_flag, 1'b1);
			kind = 2'h0;
			supply = 1'b1;
			watchdog_period_select = 1'b0;
			wait_until(0, 1'b0, 70);
			check_flag(link_flag, 1'b0);
		end
		$display("test link faults done");
		fail_force = 1'b1;
		wait_until(6, 1'b1, 4);
		repeat (4) @(negedge core_clk_i);
		fail_force = 1'b0;
		repeat (30) @(negedge core_clk_i);
		check_flag(fail_req, 1'b0);
		check_flag(fail_mode, 1'b0);
		direct = 4'h6;
		fail_force = 1'b1;
		wait_until(2, 1'b1, 20);
		check_flag(waited >= 10, 1'b1);
		wait_until(0, 1'b1, 3);
		repeat (3) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h0006);
		direct = 4'h3;
		repeat (5) @(negedge core_clk_i);
		direct = 4'h6;
		repeat (20) @(negedge core_clk_i);
		check_word({12'h000, direct_f}, 16'h0006);
		fail_force = 1'b0;
		wait_until(2, 1'b0, 20);
		check_flag(waited >= 10, 1'b1);
		wait_until(0, 1'b0, 4);
		repeat (3) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h000A);
		$display("test forced fail done");
		clk_run = 1'b0;
		wait_until(3, 1'b1, 260);
		check_flag(waited >= 90, 1'b1);
		repeat (3) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h0009);
		on_cmd = 4'h6;
		repeat (2) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h0006);
		check_flag(clk_diag, 1'b1);
		qs_pulse();
		check_flag(clk_diag, 1'b1);
		clk_run = 1'b1;
		wait_until(3, 1'b0, 200);
		repeat (3) @(negedge core_clk_i);
		check_word({12'h000, ch_out}, 16'h000A);
		check_flag(clk_diag, 1'b1);
		qs_pulse();
		check_flag(clk_diag, 1'b0);
		clk_half = 16'h0190;
		wait_until(3, 1'b1, 300);
		clk_half = 16'h09C4;
		wait_until(3, 1'b0, 300);
		$display("test clock monitor done");
		wake = 1'b0;
		wait_until(5, 1'b0, 150);
		check_flag(waited >= 90, 1'b1);
		clk_run = 1'b0;
		repeat (250) @(negedge core_clk_i);
		check_flag(clk_low, 1'b0);
		wake = 1'b1;
		wait_until(5, 1'b1, 5);
		wait_until(3, 1'b1, 260);
		check_flag(waited >= 190, 1'b1);
		$display("test sleep done");
		give_verdict();
	end
endmodule
